/* File: ir_carrier_and_timer.sv */
// Modulo timer, carrier generator control and envelope gating of the IR pin
// Assumes register-file and transfer-buffer strobes on clk_sys = fx
//
// Notes on behaviour
// - Clock select 00/01/10 give fx/32, fx/64, fx/256; 11 counts carrier.
// - Writing the clear bit zeroes counter, and match flag unless a match lands then; it reads 0.
// - Run bit 0 stops counting; 1 counts on falling count-clock edges.
// - Timer control resets to 8H; software sets run again after stop.
// - Carrier uses one counter with high and low period registers.
// - Carrier clock select picks fx/2, fx or 2fx base clock.
// - High and low periods are read and written, match period only written, via the transfer buffer.
// - Steady-high select 0 gives gated carrier, 1 gives the envelope level steady on the pin.
// - Envelope 1 puts carrier on the pin; envelope 0 drives it low.
// - Each match copies the buffered envelope into the envelope.
// - Match-time envelope cut during a high carrier phase waits for carrier low.
// - Envelope 0 halts carrier unless the timer counts the carrier.
// - Buffered envelope start delays the high pulse by one low phase.
// - Each carrier phase lasts period value plus one base-clock cycles, rounded up to even at 2fx.
// - Counter stepping to the match period sets the match flag and restarts at 0.
`timescale 1ns/100ps
`include "ir_defines.svh"
module ir_carrier_and_timer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Register file, 4-bit words
  input  wire logic [6:0]       rf_addr,
  input  wire logic             rf_we,
  input  wire logic [3:0]       rf_wdata,
  output logic      [3:0]       rf_rdata_q,
  // Peripheral registers through the transfer buffer
  input  wire logic [7:0]       periph_addr,
  input  wire logic             periph_we,
  input  wire logic             periph_re,
  input  wire logic [WIDTH-1:0] transfer_buffer,
  output logic      [WIDTH-1:0] periph_rdata_q,
  // Infrared LED drive
  output logic                  ir_out_pin
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (WIDTH != 8)
  begin : g_bad_width
    $error("timer logic serves 8-bit registers only");
  end

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_q;
  logic rst_n_q;

  // Release is synchronised; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ************************************************************
  // State
  // ************************************************************
  logic                  run_q,       run_d;
  ir_pkg::count_src_type src_q,       src_d;
  ir_pkg::base_clk_type  base_q,      base_d;
  logic                  steady_q,    steady_d;
  logic                  env_q,       env_d;
  logic                  env_next_q,  env_next_d;
  logic                  hold_q,      hold_d;
  logic                  flag_q,      flag_d;
  logic [WIDTH-1:0]      high_q,      high_d;
  logic [WIDTH-1:0]      low_q,       low_d;
  logic [WIDTH-1:0]      match_q,     match_d;
  logic [WIDTH-1:0]      cnt_q,       cnt_d;
  logic [7:0]            pre_q,       pre_d;
  logic                  lvl_q,       lvl_d;
  logic                  pin_d;
  logic [3:0]            rf_rdata_d;
  logic [WIDTH-1:0]      periph_rdata_d;
  logic                  clear_hit;
  logic                  match_hit;
  logic                  carrier_run;
  logic                  carrier;

  // ************************************************************
  // Carrier generator
  // ************************************************************
  ir_carrier_gen #(
    .WIDTH       (WIDTH)
  ) u_carrier (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n_q),
    .run         (carrier_run),
    .base_sel    (base_q),
    .high_period (high_q),
    .low_period  (low_q),
    .carrier     (carrier)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    logic sel_lvl;
    sel_lvl        = 1'b0;
    run_d          = run_q;
    src_d          = src_q;
    base_d         = base_q;
    steady_d       = steady_q;
    env_d          = env_q;
    env_next_d     = env_next_q;
    hold_d         = hold_q;
    flag_d         = flag_q;
    high_d         = high_q;
    low_d          = low_q;
    match_d        = match_q;
    cnt_d          = cnt_q;
    pre_d          = pre_q + 8'h01;
    rf_rdata_d     = 4'h0;
    periph_rdata_d = periph_rdata_q;

    // Register-file writes
    clear_hit = rf_we && (rf_addr == `RF_TIMER_CTRL) && rf_wdata[`TC_CLEAR];
    if (rf_we && rf_addr == `RF_TIMER_CTRL)
    begin
      run_d = rf_wdata[`TC_RUN];
      src_d = ir_pkg::count_src_type'(rf_wdata[1:0]);
    end
    else if (rf_we && rf_addr == `RF_CARRIER_CLK)
    begin
      base_d = ir_pkg::base_clk_type'(rf_wdata[1:0]);
    end
    else if (rf_we && rf_addr == `RF_OUT_CTRL)
    begin
      steady_d = rf_wdata[`OC_STEADY];
      env_d    = rf_wdata[`OC_ENV];
    end
    else if (rf_we && rf_addr == `RF_ENV_NEXT)
    begin
      env_next_d = rf_wdata[0];
    end
    else if (rf_we && rf_addr == `RF_IRQ)
    begin
      flag_d = rf_wdata[0];
    end

    // Peripheral writes via the transfer buffer
    if (periph_we && periph_addr == `PR_HIGH_PERIOD)
    begin
      high_d = transfer_buffer;
    end
    else if (periph_we && periph_addr == `PR_LOW_PERIOD)
    begin
      low_d = transfer_buffer;
    end
    else if (periph_we && periph_addr == `PR_MATCH_PERIOD)
    begin
      match_d = transfer_buffer;
    end

    // Count clock select and falling-edge detect
    case (src_q)
      ir_pkg::SRC_DIV32:  sel_lvl = pre_q[`TAP_DIV32];
      ir_pkg::SRC_DIV64:  sel_lvl = pre_q[`TAP_DIV64];
      ir_pkg::SRC_DIV256: sel_lvl = pre_q[`TAP_DIV256];
      default:            sel_lvl = carrier;
    endcase
    lvl_d = sel_lvl;

    // Zero match period never matches, even on counter wrap
    match_hit = run_q && lvl_q && !sel_lvl && (match_q != '0)
                && ((cnt_q + 8'h01) == match_q);
    if (clear_hit)
    begin
      cnt_d  = '0;
      flag_d = 1'b0;
    end
    else if (match_hit)
    begin
      cnt_d = '0;
    end
    else if (run_q && lvl_q && !sel_lvl)
    begin
      cnt_d = cnt_q + 8'h01;
    end
    // A match in the clearing cycle still raises the flag
    if (match_hit)
    begin
      flag_d = 1'b1;
    end

    // Envelope transfer; a cut during a high carrier phase is held off
    if (match_hit)
    begin
      env_d  = env_next_q;
      hold_d = env_q && carrier && !env_next_q;
    end
    else if (hold_q && !carrier)
    begin
      hold_d = 1'b0;
    end

    // Carrier keeps running whenever the timer counts from it
    carrier_run = env_q || hold_q || (src_q == ir_pkg::SRC_CARRIER);
    pin_d = steady_q ? env_q : (carrier && (env_q || hold_q));

    // Register-file read, one cycle behind the address
    if (rf_addr == `RF_TIMER_CTRL)
    begin
      rf_rdata_d = {run_q, 1'b0, src_q};
    end
    else if (rf_addr == `RF_IRQ)
    begin
      rf_rdata_d = {3'h0, flag_q};
    end
    else if (rf_addr == `RF_CARRIER_CLK)
    begin
      rf_rdata_d = {2'h0, base_q};
    end
    else if (rf_addr == `RF_OUT_CTRL)
    begin
      rf_rdata_d = {2'h0, steady_q, env_q};
    end
    else if (rf_addr == `RF_ENV_NEXT)
    begin
      rf_rdata_d = {3'h0, env_next_q};
    end

    // Peripheral read; match period is write-only and reads zero
    if (periph_re && periph_addr == `PR_HIGH_PERIOD)
    begin
      periph_rdata_d = high_q;
    end
    else if (periph_re && periph_addr == `PR_LOW_PERIOD)
    begin
      periph_rdata_d = low_q;
    end
    else if (periph_re && periph_addr == `PR_COUNT_VALUE)
    begin
      periph_rdata_d = cnt_q;
    end
    else if (periph_re)
    begin
      periph_rdata_d = '0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Period registers have no defined value in hardware; zero is chosen
  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      run_q          <= 1'(`TC_RESET >> `TC_RUN);
      src_q          <= ir_pkg::SRC_DIV32;
      base_q         <= ir_pkg::BASE_HALF;
      steady_q       <= 1'b0;
      env_q          <= 1'b0;
      env_next_q     <= 1'b0;
      hold_q         <= 1'b0;
      flag_q         <= 1'b0;
      high_q         <= '0;
      low_q          <= '0;
      match_q        <= '0;
      cnt_q          <= '0;
      pre_q          <= 8'h00;
      lvl_q          <= 1'b0;
      ir_out_pin     <= 1'b0;
      rf_rdata_q     <= 4'h0;
      periph_rdata_q <= '0;
    end
    else
    begin
      run_q          <= run_d;
      src_q          <= src_d;
      base_q         <= base_d;
      steady_q       <= steady_d;
      env_q          <= env_d;
      env_next_q     <= env_next_d;
      hold_q         <= hold_d;
      flag_q         <= flag_d;
      high_q         <= high_d;
      low_q          <= low_d;
      match_q        <= match_d;
      cnt_q          <= cnt_d;
      pre_q          <= pre_d;
      lvl_q          <= lvl_d;
      ir_out_pin     <= pin_d;
      rf_rdata_q     <= rf_rdata_d;
      periph_rdata_q <= periph_rdata_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_clear_zeroes_count: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    clear_hit |=> (cnt_q == '0) && !rf_rdata_q[`TC_CLEAR])
    else $error("clear did not zero counter");

  a_stop_holds_count: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (!run_q && !clear_hit) |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  a_match_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    match_hit |=> flag_q ##1 (flag_q || $past(rf_we)))
    else $error("match flag not set");

  a_match_restarts: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    match_hit |=> (cnt_q == '0) && (env_q == $past(env_next_q)))
    else $error("match did not restart or transfer");

  a_env_low_pin: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (!env_q && !hold_q) |=> !ir_out_pin)
    else $error("pin high without envelope");

  a_steady_pin: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (steady_q && env_q) |=> ir_out_pin)
    else $error("steady mode pin not high");

  a_hold_follows: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    (hold_q && carrier && !steady_q) |=> ir_out_pin)
    else $error("held carrier pulse cut short");

  a_halt_carrier: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
    !carrier_run |=> !carrier)
    else $error("carrier ran while halted");

endmodule : ir_carrier_and_timer

/* File: ir_defines.svh */
// Register offsets, field positions, reset values and divider taps
// Assumes inclusion by bare name from the carrier and timer file
`ifndef IR_DEFINES_SVH
`define IR_DEFINES_SVH

// ************************************************************
// Register-file words (4-bit wide)
// ************************************************************
`define RF_ENV_NEXT     7'h11
`define RF_OUT_CTRL     7'h12
`define RF_CARRIER_CLK  7'h13
`define RF_TIMER_CTRL   7'h33
`define RF_IRQ          7'h3f

// ************************************************************
// Peripheral registers (8-bit, via the transfer buffer)
// ************************************************************
`define PR_LOW_PERIOD   8'h02
`define PR_HIGH_PERIOD  8'h03
`define PR_MATCH_PERIOD 8'h04
`define PR_COUNT_VALUE  8'h05

// ************************************************************
// Field positions and reset values
// ************************************************************
`define TC_RUN          3
`define TC_CLEAR        2
`define OC_STEADY       1
`define OC_ENV          0
`define TC_RESET        4'h8

// ************************************************************
// Prescaler taps: bit n of a free counter runs at fx/2^(n+1)
// ************************************************************
`define TAP_DIV32       4
`define TAP_DIV64       5
`define TAP_DIV256      7

`endif

/* File: ir_pkg.sv */
// Types shared by the carrier generator and the timer
// Assumes nothing of its surroundings
package ir_pkg;

  // Count clock source of the modulo timer
  typedef enum logic [1:0] {SRC_DIV32, SRC_DIV64, SRC_DIV256, SRC_CARRIER} count_src_type;

  // Carrier base clock
  typedef enum logic [1:0] {BASE_HALF, BASE_FULL, BASE_DOUBLE, BASE_SPARE} base_clk_type;

  // Carrier phase
  typedef enum logic {PHASE_LOW, PHASE_HIGH} phase_type;

endpackage : ir_pkg

/* File: ir_carrier_gen.sv */
// Carrier generator: one phase counter, high and low period inputs
// Assumes synchronous active-low reset copy and one clock, clk_sys = fx
`timescale 1ns/100ps
module ir_carrier_gen #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Control
  input  wire logic             run,
  input  wire logic [1:0]       base_sel,
  input  wire logic [WIDTH-1:0] high_period,
  input  wire logic [WIDTH-1:0] low_period,
  // Carrier level
  output logic                  carrier
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (WIDTH < 2 || WIDTH > 16)
  begin : g_bad_width
    $error("carrier width out of range");
  end

  logic                  half_q;
  logic                  half_d;
  logic [WIDTH:0]        cnt_q;
  logic [WIDTH:0]        cnt_d;
  ir_pkg::phase_type     ph_q;
  ir_pkg::phase_type     ph_d;

  assign carrier = (ph_q == ir_pkg::PHASE_HIGH);

  // ************************************************************
  // Phase counter
  // ************************************************************
  // Double base clock advances two units per fx cycle, so odd lengths round up
  always_comb
  begin
    logic [1:0]       step;
    logic [WIDTH:0]   limit;
    logic [WIDTH+1:0] nxt;
    step   = 2'd1;
    limit  = '0;
    nxt    = '0;
    half_d = ~half_q;
    ph_d   = ph_q;
    cnt_d  = cnt_q;
    case (ir_pkg::base_clk_type'(base_sel))
      ir_pkg::BASE_HALF:   step = half_q ? 2'd1 : 2'd0;
      ir_pkg::BASE_DOUBLE: step = 2'd2;
      default:             step = 2'd1;
    endcase
    limit = (ph_q == ir_pkg::PHASE_HIGH) ? {1'b0, high_period} : {1'b0, low_period};
    nxt   = {1'b0, cnt_q} + {{WIDTH{1'b0}}, step};
    // Halted generator parks in the low phase, so a restart begins low
    if (!run)
    begin
      ph_d  = ir_pkg::PHASE_LOW;
      cnt_d = '0;
    end
    else if (step != 2'd0)
    begin
      if (nxt > {1'b0, limit})
      begin
        cnt_d = '0;
        ph_d  = (ph_q == ir_pkg::PHASE_HIGH) ? ir_pkg::PHASE_LOW : ir_pkg::PHASE_HIGH;
      end
      else
      begin
        cnt_d = nxt[WIDTH:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_q <= 1'b0;
      cnt_q  <= '0;
      ph_q   <= ir_pkg::PHASE_LOW;
    end
    else
    begin
      half_q <= half_d;
      cnt_q  <= cnt_d;
      ph_q   <= ph_d;
    end
  end

  // Zero period at full rate gives a one-cycle high phase
  a_phase_high_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (run && base_sel == 2'd1 && ph_q == ir_pkg::PHASE_HIGH && cnt_q == {1'b0, high_period})
    |=> (ph_q == ir_pkg::PHASE_LOW || !run))
    else $error("high phase length wrong");

endmodule : ir_carrier_gen

/* File: ir_led_model.sv */
// IR LED model: measures lit and dark stretches on the carrier pin
// Assumes the pin is a registered output sampled on clk_sys rising edges
`timescale 1ns/100ps
module ir_led_model (
  // Clock
  input  wire logic clk_sys,
  // LED drive
  input  wire logic ir_out_pin,
  // Last stretch widths in clock cycles, and edge count
  output int        high_len,
  output int        low_len,
  output int        edges
);
  // ************************************************************
  // Stretch measurement
  // ************************************************************
  int   run_len;
  logic last;

  // The LED has no memory; only widths matter to the receiver
  initial
  begin
    run_len  = 0;
    last     = 1'b0;
    high_len = 0;
    low_len  = 0;
    edges    = 0;
  end

  // A stretch closes when the pin changes level
  always @(posedge clk_sys)
  begin
    if (ir_out_pin !== last)
    begin
      if (last === 1'b1)
        high_len = run_len;
      else
        low_len = run_len;
      edges++;
      run_len = 1;
      last    = ir_out_pin;
    end
    else
      run_len++;
  end
endmodule : ir_led_model

/* File: tb_top.sv */
// Testbench for the IR carrier and modulo timer block
// Assumes a 50 MHz clk_sys and the LED model on the pin
`timescale 1ns/100ps
module tb_top;
  // ************************************************************
  // Signals and tables
  // ************************************************************
  typedef struct packed {
    logic       is_rf;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_type;

  logic       clk_sys;
  logic       nrst;
  logic [6:0] rf_addr;
  logic       rf_we;
  logic [3:0] rf_wdata;
  logic [3:0] rf_rdata_q;
  logic [7:0] periph_addr;
  logic       periph_we;
  logic       periph_re;
  logic [7:0] transfer_buffer;
  logic [7:0] periph_rdata_q;
  logic       ir_out_pin;
  logic [7:0] v;
  logic [7:0] c1;
  int         high_len;
  int         low_len;
  int         edges;
  int         e;
  int         fail_count = 0;
  int         checked    = 0;
  int         cyc        = 0;
  time        t1;
  int         hexp[3]    = '{6, 3, 2};
  int         lexp[3]    = '{10, 5, 3};
  int         texp[3]    = '{96, 192, 768};
  // Write then read back; clear bit and write-only places read 0
  row_type    rows[8]    = '{
    '{1'b1, 8'h33, 8'h0f, 8'h0b},
    '{1'b1, 8'h13, 8'h02, 8'h02},
    '{1'b1, 8'h12, 8'h02, 8'h02},
    '{1'b1, 8'h11, 8'h01, 8'h01},
    '{1'b1, 8'h20, 8'h0f, 8'h00},
    '{1'b0, 8'h03, 8'ha5, 8'ha5},
    '{1'b0, 8'h02, 8'h5a, 8'h5a},
    '{1'b0, 8'h04, 8'h10, 8'h00}};

  ir_carrier_and_timer i_ir_carrier_and_timer (
    .clk_sys(clk_sys), .nrst(nrst), .rf_addr(rf_addr), .rf_we(rf_we),
    .rf_wdata(rf_wdata), .rf_rdata_q(rf_rdata_q), .periph_addr(periph_addr),
    .periph_we(periph_we), .periph_re(periph_re),
    .transfer_buffer(transfer_buffer), .periph_rdata_q(periph_rdata_q),
    .ir_out_pin(ir_out_pin));

  ir_led_model i_ir_led_model (
    .clk_sys(clk_sys), .ir_out_pin(ir_out_pin), .high_len(high_len),
    .low_len(low_len), .edges(edges));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One write through the register file or the transfer buffer
  task automatic wr(input logic rf, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    rf_addr         = a[6:0];
    rf_wdata        = d[3:0];
    rf_we           = rf;
    periph_addr     = a;
    transfer_buffer = d;
    periph_we       = !rf;
    @(negedge clk_sys);
    rf_we     = 1'b0;
    periph_we = 1'b0;
  endtask : wr

  task automatic rd(input logic rf, input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    rf_addr     = a[6:0];
    periph_addr = a;
    periph_re   = !rf;
    @(negedge clk_sys);
    periph_re = 1'b0;
    d         = rf ? {4'h0, rf_rdata_q} : periph_rdata_q;
  endtask : rd

  // Polls the match flag every cycle, so arrival time is exact
  task automatic wait_flag(output time t);
    int n;
    n = 0;
    @(negedge clk_sys);
    rf_addr = 7'h3f;
    @(negedge clk_sys);
    while (rf_rdata_q[0] !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    t = $time;
    check(16'(rf_rdata_q[0]), 16'h1);
    wr(1'b1, 8'h3f, 8'h00);
  endtask : wait_flag

  // First two intervals after a change are discarded
  task automatic interval(input int exp_cyc);
    time t2;
    wait_flag(t1);
    wait_flag(t1);
    wait_flag(t2);
    check(16'((t2 - t1) / 20), 16'(exp_cyc));
  endtask : interval

  task automatic test_done;
    $display("counts: checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // ************************************************************
  // Clock, timeout and sequence
  // ************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Whole run needs well under this many cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  initial
  begin
    nrst            = 1'b0;
    rf_addr         = 7'h00;
    rf_we           = 1'b0;
    rf_wdata        = 4'h0;
    periph_addr     = 8'h00;
    periph_we       = 1'b0;
    periph_re       = 1'b0;
    transfer_buffer = 8'h00;
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(1'b0, 8'h05, v);
    check(16'(v), 16'h0);
    rd(1'b1, 8'h33, v);
    check(16'(v), 16'h8);
    rd(1'b1, 8'h3f, v);
    check(16'(v), 16'h0);
    check(16'(ir_out_pin), 16'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].is_rf, rows[i].addr, rows[i].wdata);
      rd(rows[i].is_rf, rows[i].addr, v);
      check(16'(v), 16'(rows[i].exp));
    end
    $display("test registers done");
    // Carrier phases of 3 and 5 base cycles at fx/2 and fx, 4 and 6 at 2fx
    wr(1'b1, 8'h33, 8'h04);
    wr(1'b0, 8'h03, 8'h02);
    wr(1'b0, 8'h02, 8'h04);
    wr(1'b1, 8'h12, 8'h01);
    for (int b = 0; b < 3; b++)
    begin
      wr(1'b1, 8'h13, 8'(b));
      repeat (60) @(negedge clk_sys);
      check(16'(high_len), 16'(hexp[b]));
      check(16'(low_len), 16'(lexp[b]));
    end
    $display("test carrier done");
    wr(1'b1, 8'h12, 8'h03);
    repeat (2) @(negedge clk_sys); // Let the pin and the model settle
    e = edges;
    repeat (20) @(negedge clk_sys);
    check(16'(ir_out_pin), 16'h1);
    check(16'(edges - e), 16'h0);
    wr(1'b1, 8'h12, 8'h00);
    repeat (4) @(negedge clk_sys);
    e = edges;
    repeat (40) @(negedge clk_sys);
    check(16'(edges - e), 16'h0);
    check(16'(ir_out_pin), 16'h0);
    $display("test steady done");
    // Match period 3 at each prescaled count clock
    wr(1'b0, 8'h04, 8'h03);
    for (int s = 0; s < 3; s++)
    begin
      wr(1'b1, 8'h33, 8'hc | 8'(s));
      rd(1'b1, 8'h3f, v);
      check(16'(v), 16'h0);
      interval(texp[s]);
    end
    rd(1'b1, 8'h12, v);
    check(16'(v), 16'h1);
    wr(1'b1, 8'h11, 8'h00);
    wait_flag(t1);
    rd(1'b1, 8'h12, v);
    check(16'(v), 16'h0);
    $display("test timer done");
    // Count the carrier with envelope off: carrier must keep running
    wr(1'b0, 8'h03, 8'h03);
    wr(1'b0, 8'h02, 8'h03);
    wr(1'b1, 8'h13, 8'h01);
    wr(1'b1, 8'h33, 8'h0f);
    interval(24);
    $display("test carrier count done");
    // Long high phase: a match that drops the envelope keeps it whole
    wr(1'b0, 8'h04, 8'h02);
    wr(1'b0, 8'h03, 8'h1f);
    wr(1'b0, 8'h02, 8'h00);
    wr(1'b1, 8'h33, 8'h0c);
    wr(1'b1, 8'h12, 8'h01);
    wait_flag(t1);
    repeat (40) @(negedge clk_sys);
    check(16'(high_len), 16'd32);
    check(16'(ir_out_pin), 16'h0);
    $display("test hold done");
    // Stopping the count freezes the counter
    wr(1'b0, 8'h04, 8'hff);
    wr(1'b1, 8'h33, 8'h0c);
    repeat (200) @(negedge clk_sys);
    wr(1'b1, 8'h33, 8'h00);
    rd(1'b0, 8'h05, c1);
    check(16'(c1 > 8'h05 && c1 < 8'h08), 16'h1);
    repeat (100) @(negedge clk_sys);
    rd(1'b0, 8'h05, v);
    check(16'(v), 16'(c1));
    $display("test stop done");
    test_done();
  end
endmodule : tb_top
